// File: hdl/core_alu_rotate_sub_xor_ops.sv
// execution datapath: rotate, subtract, swap, xor, direction load,
// sleep with watchdog clear, file array and apb slave.
// assumes one instruction per valid cycle and apb,
// both synchronous to CLK_I.
//
// The address map and register access over APB were decided locally.
`default_nettype none

// Operation
// - file address 0..127; dest 0 to work, 1 to file.
// - rotate right via carry; only carry changes.
// - literal minus work into work.
// - subtracts set carry, digit carry as no-borrow; zero too.
// - file minus work to chosen destination.
// - file minus work minus inverted carry, flags updated.
// - sleep clears watchdog and prescaler, stops oscillator.
// - sleep clears power-down, sets time-out status.
// - nibble exchange of file byte, no flags.
// - xor literal into work, only zero changes.
// - xor work with file to destination, only zero changes.
// - direction load copies work to port 5, 6, 7 register.
module core_alu_rotate_sub_xor_ops
    import alu_ops_pkg::*;
#(
    parameter int PRESCALE_W = 8
)
(
    // clock, reset, enable
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    // decoder side
    input wire logic INSTR_VALID_I,
    input wire instr_s INSTR_I,
    input wire logic WAKE_I,
    output logic INSTR_DONE_O,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [APB_AW-1:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic PREADY_O,
    output logic [31:0] PRDATA_O,
    output logic PSLVERR_O,
    // core state
    output logic [DATA_W-1:0] WORK_O,
    output logic [DATA_W-1:0] STATUS_O,
    output logic [DATA_W-1:0] PORT_ONE_DIRECTION_O,
    output logic [DATA_W-1:0] PORT_TWO_DIRECTION_O,
    output logic [DATA_W-1:0] PORT_THREE_DIRECTION_O,
    output logic OSC_STOPPED_O
);

    ////////////////////////////////
    // state

    logic [DATA_W-1:0] file_mem [0:FILE_DEPTH-1];
    logic [DATA_W-1:0] work_ff;
    flags_s flags_ff;
    logic powerdown_status_ff;
    logic timeout_status_ff;
    logic [DATA_W-1:0] port_one_direction_ff;
    logic [DATA_W-1:0] port_two_direction_ff;
    logic [DATA_W-1:0] port_three_direction_ff;
    logic [DATA_W-1:0] watchdog_counter_ff;
    logic [PRESCALE_W-1:0] prescale_ff;
    logic watchdog_en_ff;
    logic [FADDR_W-1:0] file_ptr_ff;
    core_state_e state_ff;
    core_state_e nxt_state;
    logic done_ff;
    logic pready_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    ////////////////////////////////
    // decode helpers

    function automatic logic writes_dest(input op_e op);
        case (op)
            OP_ROTATE_RIGHT_VIA_CARRY, OP_SUB_WORK_FROM_FILE,
            OP_SUB_WORK_FROM_FILE_BORROW, OP_NIBBLE_EXCHANGE,
            OP_XOR_WORK_WITH_FILE:
                writes_dest = 1'b1;
            default:
                writes_dest = 1'b0;
        endcase
    endfunction

    function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
        case (a)
            ADDR_WORK, ADDR_STATUS, ADDR_PORT_ONE_DIR, ADDR_PORT_TWO_DIR,
            ADDR_PORT_THREE_DIR, ADDR_WATCHDOG, ADDR_FILE_PTR,
            ADDR_FILE_DATA, ADDR_SLEEP:
                addr_mapped = 1'b1;
            default:
                addr_mapped = 1'b0;
        endcase
    endfunction

    ////////////////////////////////
    // instruction issue and alu

    logic exec;
    logic [DATA_W-1:0] file_operand;
    logic [DATA_W-1:0] alu_result;
    flags_s alu_flags;
    logic to_file;
    logic to_work;
    logic is_sleep;

    assign exec = CE_I && INSTR_VALID_I && (state_ff == CORE_RUN);
    assign file_operand = file_mem[INSTR_I.file_addr];
    assign to_file = writes_dest(INSTR_I.op) && INSTR_I.dest_file;
    assign to_work = (writes_dest(INSTR_I.op) && !INSTR_I.dest_file)
        || (INSTR_I.op == OP_SUB_WORK_FROM_LITERAL)
        || (INSTR_I.op == OP_XOR_LITERAL_INTO_WORK);
    assign is_sleep = exec && (INSTR_I.op == OP_SLEEP);

    alu_core_calc u_calc (
        .op_i(INSTR_I.op),
        .work_i(work_ff),
        .file_i(file_operand),
        .literal_i(INSTR_I.literal),
        .flags_i(flags_ff),
        .result_o(alu_result),
        .flags_o(alu_flags)
    );

    ////////////////////////////////
    // apb: one wait state, answer registered

    logic apb_do;
    logic apb_wr;
    logic apb_bad;

    assign apb_do = CE_I && PSEL_I && PENABLE_I && !pready_ff;
    assign apb_bad = !addr_mapped(PADDR_I);
    assign apb_wr = apb_do && PWRITE_I && !apb_bad;

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
        else if (CE_I)
        begin
            pready_ff <= apb_do;
            pslverr_ff <= apb_do && apb_bad;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            prdata_ff <= 32'h0000_0000;
        else if (apb_do)
        begin
            prdata_ff <= 32'h0000_0000;
            case (PADDR_I)
                ADDR_WORK: prdata_ff[DATA_W-1:0] <= work_ff;
                ADDR_STATUS: prdata_ff[DATA_W-1:0] <= STATUS_O;
                ADDR_PORT_ONE_DIR: prdata_ff[DATA_W-1:0] <= port_one_direction_ff;
                ADDR_PORT_TWO_DIR: prdata_ff[DATA_W-1:0] <= port_two_direction_ff;
                ADDR_PORT_THREE_DIR: prdata_ff[DATA_W-1:0] <= port_three_direction_ff;
                ADDR_WATCHDOG:
                begin
                    prdata_ff[WD_ENABLE_BIT] <= watchdog_en_ff;
                    prdata_ff[WD_COUNT_LSB +: DATA_W] <= watchdog_counter_ff;
                end
                ADDR_FILE_PTR: prdata_ff[FADDR_W-1:0] <= file_ptr_ff;
                ADDR_FILE_DATA: prdata_ff[DATA_W-1:0] <= file_mem[file_ptr_ff];
                ADDR_SLEEP: prdata_ff[SLEEP_BIT] <= (state_ff == CORE_ASLEEP);
                default: prdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////
    // file array: software write wins over instruction write

    always_ff @(posedge CLK_I)
    begin
        if (apb_wr && (PADDR_I == ADDR_FILE_DATA))
            file_mem[file_ptr_ff] <= PWDATA_I[DATA_W-1:0];
        else if (exec && to_file)
            file_mem[INSTR_I.file_addr] <= alu_result;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            file_ptr_ff <= {FADDR_W{1'b0}};
        else if (apb_wr && (PADDR_I == ADDR_FILE_PTR))
            file_ptr_ff <= PWDATA_I[FADDR_W-1:0];
    end

    ////////////////////////////////
    // working register and flags

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            work_ff <= WORK_RST;
        else if (apb_wr && (PADDR_I == ADDR_WORK))
            work_ff <= PWDATA_I[DATA_W-1:0];
        else if (exec && to_work)
            work_ff <= alu_result;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            flags_ff <= '0;
        else if (apb_wr && (PADDR_I == ADDR_STATUS))
        begin
            flags_ff.carry <= PWDATA_I[ST_CARRY];
            flags_ff.digit_carry_flag <= PWDATA_I[ST_DIGIT];
            flags_ff.zero <= PWDATA_I[ST_ZERO];
        end
        else if (exec)
            flags_ff <= alu_flags;
    end

    ////////////////////////////////
    // direction registers; other operands ignored

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            port_one_direction_ff <= DIR_RST;
            port_two_direction_ff <= DIR_RST;
            port_three_direction_ff <= DIR_RST;
        end
        else if (exec && (INSTR_I.op == OP_LOAD_PORT_DIRECTION))
        begin
            case (INSTR_I.file_addr)
                DIR_SEL_ONE: port_one_direction_ff <= work_ff;
                DIR_SEL_TWO: port_two_direction_ff <= work_ff;
                DIR_SEL_THREE: port_three_direction_ff <= work_ff;
                default: port_one_direction_ff <= port_one_direction_ff;
            endcase
        end
    end

    ////////////////////////////////
    // watchdog: a counter wrap is a time-out

    logic prescale_tick;
    logic watchdog_wrap;

    assign prescale_tick = watchdog_en_ff && (&prescale_ff);
    assign watchdog_wrap = prescale_tick && (watchdog_counter_ff == WATCHDOG_LAST);

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            watchdog_en_ff <= 1'b0;
        else if (apb_wr && (PADDR_I == ADDR_WATCHDOG))
            watchdog_en_ff <= PWDATA_I[WD_ENABLE_BIT];
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            prescale_ff <= {PRESCALE_W{1'b0}};
            watchdog_counter_ff <= WATCHDOG_CLEAR;
        end
        else if (is_sleep)
        begin
            prescale_ff <= {PRESCALE_W{1'b0}};
            watchdog_counter_ff <= WATCHDOG_CLEAR;
        end
        else if (CE_I && watchdog_en_ff)
        begin
            prescale_ff <= prescale_ff + {{(PRESCALE_W-1){1'b0}}, 1'b1};
            if (prescale_tick)
                watchdog_counter_ff <= watchdog_counter_ff + 8'h01;
        end
    end

    ////////////////////////////////
    // status bits; sleep wins over a same-cycle time-out

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
        begin
            powerdown_status_ff <= 1'b1;
            timeout_status_ff <= 1'b1;
        end
        else if (is_sleep)
        begin
            powerdown_status_ff <= 1'b0;
            timeout_status_ff <= 1'b1;
        end
        else if (CE_I && watchdog_wrap)
            timeout_status_ff <= 1'b0;
    end

    ////////////////////////////////
    // run / sleep sequencer

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            CORE_RUN:
                if (is_sleep)
                    nxt_state = CORE_ASLEEP;
            CORE_ASLEEP:
                if (WAKE_I || watchdog_wrap
                    || (apb_wr && (PADDR_I == ADDR_SLEEP) && !PWDATA_I[SLEEP_BIT]))
                    nxt_state = CORE_RUN;
            default:
                nxt_state = CORE_RUN;
        endcase
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            state_ff <= CORE_RUN;
        else if (CE_I)
            state_ff <= nxt_state;
    end

    always_ff @(posedge CLK_I)
    begin
        if (!RESET_N_I)
            done_ff <= 1'b0;
        else if (CE_I)
            done_ff <= exec;
    end

    ////////////////////////////////
    // outputs, all from flip-flops

    assign INSTR_DONE_O = done_ff;
    assign PREADY_O = pready_ff;
    assign PRDATA_O = prdata_ff;
    assign PSLVERR_O = pslverr_ff;
    assign WORK_O = work_ff;
    assign STATUS_O = {3'b000, timeout_status_ff, powerdown_status_ff,
        flags_ff.zero, flags_ff.digit_carry_flag, flags_ff.carry};
    assign PORT_ONE_DIRECTION_O = port_one_direction_ff;
    assign PORT_TWO_DIRECTION_O = port_two_direction_ff;
    assign PORT_THREE_DIRECTION_O = port_three_direction_ff;
    assign OSC_STOPPED_O = (state_ff == CORE_ASLEEP);

endmodule

`default_nettype wire

// File: shared/alu_ops_pkg.sv
// package for the rotate / subtract / xor execution datapath.
// assumes a single core clock; shared by the datapath top and its alu leaf.
`default_nettype none

package alu_ops_pkg;

    ////////////////////////////////
    // widths

    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int FILE_DEPTH = 128;
    localparam int NIBBLE_W = 4;
    localparam int APB_AW = 8;

    ////////////////////////////////
    // apb byte offsets

    localparam logic [APB_AW-1:0] ADDR_WORK = 8'h00;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] ADDR_PORT_ONE_DIR = 8'h08;
    localparam logic [APB_AW-1:0] ADDR_PORT_TWO_DIR = 8'h0C;
    localparam logic [APB_AW-1:0] ADDR_PORT_THREE_DIR = 8'h10;
    localparam logic [APB_AW-1:0] ADDR_WATCHDOG = 8'h14;
    localparam logic [APB_AW-1:0] ADDR_FILE_PTR = 8'h18;
    localparam logic [APB_AW-1:0] ADDR_FILE_DATA = 8'h1C;
    localparam logic [APB_AW-1:0] ADDR_SLEEP = 8'h20;

    ////////////////////////////////
    // bit positions and reset values

    localparam int ST_CARRY = 0;
    localparam int ST_DIGIT = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWERDOWN = 3;
    localparam int ST_TIMEOUT = 4;
    localparam int WD_ENABLE_BIT = 0;
    localparam int WD_COUNT_LSB = 8;
    localparam int SLEEP_BIT = 0;

    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [DATA_W-1:0] DIR_RST = 8'hFF;
    localparam logic [DATA_W-1:0] WATCHDOG_CLEAR = 8'h00;
    localparam logic [DATA_W-1:0] WATCHDOG_LAST = 8'hFF;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // direction-load operands
    localparam logic [FADDR_W-1:0] DIR_SEL_ONE = 7'h05;
    localparam logic [FADDR_W-1:0] DIR_SEL_TWO = 7'h06;
    localparam logic [FADDR_W-1:0] DIR_SEL_THREE = 7'h07;

    ////////////////////////////////
    // types

    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_ROTATE_RIGHT_VIA_CARRY = 4'h1,
        OP_SUB_WORK_FROM_LITERAL = 4'h2,
        OP_SUB_WORK_FROM_FILE = 4'h3,
        OP_SUB_WORK_FROM_FILE_BORROW = 4'h4,
        OP_NIBBLE_EXCHANGE = 4'h5,
        OP_XOR_LITERAL_INTO_WORK = 4'h6,
        OP_XOR_WORK_WITH_FILE = 4'h7,
        OP_LOAD_PORT_DIRECTION = 4'h8,
        OP_SLEEP = 4'h9
    } op_e;

    typedef enum logic [1:0] {
        CORE_RUN = 2'b01,
        CORE_ASLEEP = 2'b10
    } core_state_e;

    typedef struct packed {
        op_e op;
        logic [FADDR_W-1:0] file_addr;
        logic dest_file;
        logic [DATA_W-1:0] literal;
    } instr_s;

    typedef struct packed {
        logic carry;
        logic digit_carry_flag;
        logic zero;
    } flags_s;

endpackage

`default_nettype wire

// File: hdl/alu_core_calc.sv
// combinational arithmetic for the datapath: result and new arithmetic flags.
// assumes the caller supplies the file operand already read from data memory.
`default_nettype none

module alu_core_calc
    import alu_ops_pkg::*;
(
    // operands
    input wire op_e op_i,
    input wire logic [DATA_W-1:0] work_i,
    input wire logic [DATA_W-1:0] file_i,
    input wire logic [DATA_W-1:0] literal_i,
    input wire flags_s flags_i,
    // results
    output logic [DATA_W-1:0] result_o,
    output flags_s flags_o
);

    ////////////////////////////////
    // a - b - borrow as a + ~b + carry_in: carry out is "no borrow"

    function automatic logic [DATA_W+1:0] sub_calc(
        input logic [DATA_W-1:0] a,
        input logic [DATA_W-1:0] b,
        input logic cin
    );
        logic [DATA_W:0] full;
        logic [NIBBLE_W:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {{DATA_W{1'b0}}, cin};
        low = {1'b0, a[NIBBLE_W-1:0]} + {1'b0, ~b[NIBBLE_W-1:0]}
            + {{NIBBLE_W{1'b0}}, cin};
        sub_calc = {full[DATA_W], low[NIBBLE_W], full[DATA_W-1:0]};
    endfunction

    logic [DATA_W+1:0] sub_res;

    always_comb
    begin
        result_o = work_i;
        flags_o = flags_i;
        sub_res = sub_calc(file_i, work_i, 1'b1);
        case (op_i)
            OP_ROTATE_RIGHT_VIA_CARRY:
            begin
                result_o = {flags_i.carry, file_i[DATA_W-1:1]};
                flags_o.carry = file_i[0];
            end
            OP_SUB_WORK_FROM_LITERAL, OP_SUB_WORK_FROM_FILE,
            OP_SUB_WORK_FROM_FILE_BORROW:
            begin
                if (op_i == OP_SUB_WORK_FROM_LITERAL)
                    sub_res = sub_calc(literal_i, work_i, 1'b1);
                else if (op_i == OP_SUB_WORK_FROM_FILE_BORROW)
                    sub_res = sub_calc(file_i, work_i, flags_i.carry);
                else
                    sub_res = sub_calc(file_i, work_i, 1'b1);
                result_o = sub_res[DATA_W-1:0];
                flags_o.carry = sub_res[DATA_W+1];
                flags_o.digit_carry_flag = sub_res[DATA_W];
                flags_o.zero = (sub_res[DATA_W-1:0] == ZERO_BYTE);
            end
            OP_NIBBLE_EXCHANGE:
                result_o = {file_i[NIBBLE_W-1:0], file_i[DATA_W-1:NIBBLE_W]};
            OP_XOR_LITERAL_INTO_WORK:
            begin
                result_o = work_i ^ literal_i;
                flags_o.zero = ((work_i ^ literal_i) == ZERO_BYTE);
            end
            OP_XOR_WORK_WITH_FILE:
            begin
                result_o = work_i ^ file_i;
                flags_o.zero = ((work_i ^ file_i) == ZERO_BYTE);
            end
            default:
                result_o = work_i;
        endcase
    end

endmodule

`default_nettype wire

// File: tb/alu_ops_asserts.sv
// port checks on the execution datapath top.
// assumes apb never overlaps an instruction.
`default_nettype none

module alu_ops_asserts
    import alu_ops_pkg::*;
(
    // clock and control
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic CE_I,
    // decoder side
    input wire logic INSTR_VALID_I,
    input wire instr_s INSTR_I,
    input wire logic WAKE_I,
    input wire logic INSTR_DONE_O,
    // core state
    input wire logic [DATA_W-1:0] WORK_O,
    input wire logic [DATA_W-1:0] STATUS_O,
    input wire logic [DATA_W-1:0] PORT_ONE_DIRECTION_O,
    input wire logic [DATA_W-1:0] PORT_TWO_DIRECTION_O,
    input wire logic [DATA_W-1:0] PORT_THREE_DIRECTION_O,
    input wire logic OSC_STOPPED_O
);
    logic take;
    op_e op;
    assign take = CE_I && INSTR_VALID_I && !OSC_STOPPED_O;
    assign op = INSTR_I.op;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    ////////////////////////////////
    a_done_follows: assert property (take |=> INSTR_DONE_O)
        else $error("no done");
    a_asleep_dropped: assert property (
        INSTR_VALID_I && OSC_STOPPED_O && !WAKE_I |=> !INSTR_DONE_O && $stable(WORK_O))
        else $error("ran while asleep");
    a_sublit_value: assert property (
        take && op == OP_SUB_WORK_FROM_LITERAL
        |=> WORK_O == $past(INSTR_I.literal) - $past(WORK_O))
        else $error("literal minus work");
    a_sub_carries: assert property (
        take && op == OP_SUB_WORK_FROM_LITERAL
        |=> STATUS_O[ST_CARRY] == ($past(WORK_O) <= $past(INSTR_I.literal))
        && STATUS_O[ST_DIGIT] == ($past(WORK_O[3:0]) <= $past(INSTR_I.literal[3:0])))
        else $error("subtract carries");
    a_xorlit_zero: assert property (
        take && op == OP_XOR_LITERAL_INTO_WORK
        |=> WORK_O == ($past(WORK_O) ^ $past(INSTR_I.literal))
        && STATUS_O[ST_ZERO] == (WORK_O == 8'h00) && $stable(STATUS_O[1:0]))
        else $error("xor literal");
    a_rotate_carry_only: assert property (
        take && op == OP_ROTATE_RIGHT_VIA_CARRY |=> $stable(STATUS_O[7:1]))
        else $error("rotate flags");
    a_no_flag_ops: assert property (
        take && (op == OP_NIBBLE_EXCHANGE || op == OP_LOAD_PORT_DIRECTION)
        |=> $stable(STATUS_O))
        else $error("flag-free op changed status");
    a_dir_load: assert property (
        take && op == OP_LOAD_PORT_DIRECTION |=>
        PORT_ONE_DIRECTION_O == ($past(INSTR_I.file_addr) == DIR_SEL_ONE ?
            $past(WORK_O) : $past(PORT_ONE_DIRECTION_O)) &&
        PORT_TWO_DIRECTION_O == ($past(INSTR_I.file_addr) == DIR_SEL_TWO ?
            $past(WORK_O) : $past(PORT_TWO_DIRECTION_O)) &&
        PORT_THREE_DIRECTION_O == ($past(INSTR_I.file_addr) == DIR_SEL_THREE ?
            $past(WORK_O) : $past(PORT_THREE_DIRECTION_O)))
        else $error("wrong direction port");
    a_sleep_status: assert property (
        take && op == OP_SLEEP |=> OSC_STOPPED_O && STATUS_O[ST_TIMEOUT]
        && !STATUS_O[ST_POWERDOWN] && $stable(STATUS_O[2:0]))
        else $error("sleep status");
    a_subf_zero: assert property (
        take && !INSTR_I.dest_file
        && (op == OP_SUB_WORK_FROM_FILE || op == OP_SUB_WORK_FROM_FILE_BORROW)
        |=> STATUS_O[ST_ZERO] == (WORK_O == 8'h00))
        else $error("zero flag");

    c_sleep: cover property (take && op == OP_SLEEP);
    c_borrow_file: cover property (take && op == OP_SUB_WORK_FROM_FILE_BORROW && INSTR_I.dest_file);
    c_dropped: cover property (INSTR_VALID_I && OSC_STOPPED_O);
endmodule

bind core_alu_rotate_sub_xor_ops alu_ops_asserts i_alu_ops_asserts (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CE_I(CE_I), .INSTR_VALID_I(INSTR_VALID_I),
    .INSTR_I(INSTR_I), .WAKE_I(WAKE_I), .INSTR_DONE_O(INSTR_DONE_O), .WORK_O(WORK_O),
    .STATUS_O(STATUS_O), .PORT_ONE_DIRECTION_O(PORT_ONE_DIRECTION_O),
    .PORT_TWO_DIRECTION_O(PORT_TWO_DIRECTION_O),
    .PORT_THREE_DIRECTION_O(PORT_THREE_DIRECTION_O), .OSC_STOPPED_O(OSC_STOPPED_O));

`default_nettype wire

// File: tb/alu_decoder_model.sv
// decoder model: one instruction per valid cycle.
// assumes serial issues; gap cycles mimic a slow decoder.
`default_nettype none

module alu_decoder_model
    import alu_ops_pkg::*;
(
    // clock
    input wire logic clk_i,
    // instruction out
    output logic valid_o,
    output instr_s instr_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        valid_o = 1'b0;
        instr_o = '0;
    end

    task automatic issue(input instr_s ins, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        valid_o <= 1'b1;
        instr_o <= ins;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // released fields show the inverse so a stale operand cannot pass
        instr_o <= instr_s'(~ins);
    endtask
endmodule

`default_nettype wire

// File: tb/core_alu_rotate_sub_xor_ops_tb_top.sv
// random and corner-case bench for the execution datapath.
// assumes done follows each taken instruction.
`default_nettype none

module core_alu_rotate_sub_xor_ops_tb_top
    import alu_ops_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wake = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] seed = 32'h2D97E73A;
    logic pready, pslverr, done, valid, stopped;
    logic [7:0] work, status, dir1, dir2, dir3;
    instr_s instr;
    int bad_count = 0;
    int total_checks = 0;

    always #5 clk = ~clk;

    core_alu_rotate_sub_xor_ops #(.PRESCALE_W(2)) i_core_alu_rotate_sub_xor_ops (
        .CLK_I(clk), .RESET_N_I(rst_n), .CE_I(1'b1), .INSTR_VALID_I(valid),
        .INSTR_I(instr), .WAKE_I(wake), .INSTR_DONE_O(done), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr), .WORK_O(work),
        .STATUS_O(status), .PORT_ONE_DIRECTION_O(dir1), .PORT_TWO_DIRECTION_O(dir2),
        .PORT_THREE_DIRECTION_O(dir3), .OSC_STOPPED_O(stopped));

    alu_decoder_model i_alu_decoder_model (.clk_i(clk), .valid_o(valid), .instr_o(instr));

    ////////////////////////////////
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // returns result then status bits 2:0 (zero, digit carry, carry)
    function automatic logic [10:0] expect_of(input op_e op, input logic [7:0] f,
            input logic [7:0] w, input logic [7:0] k, input logic [2:0] fl);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] a;
        logic cin;
        a = (op == OP_SUB_WORK_FROM_LITERAL) ? k : f;
        cin = (op == OP_SUB_WORK_FROM_FILE_BORROW) ? fl[0] : 1'b1;
        s = {1'b0, a} + {1'b0, ~w} + 9'(cin);
        h = {1'b0, a[3:0]} + {1'b0, ~w[3:0]} + 5'(cin);
        case (op)
            OP_ROTATE_RIGHT_VIA_CARRY: return {fl[0], f[7:1], fl[2:1], f[0]};
            OP_NIBBLE_EXCHANGE: return {f[3:0], f[7:4], fl};
            OP_XOR_LITERAL_INTO_WORK: return {w ^ k, (w ^ k) == 8'h00, fl[1:0]};
            OP_XOR_WORK_WITH_FILE: return {w ^ f, (w ^ f) == 8'h00, fl[1:0]};
            default: return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
        endcase
    endfunction

    task automatic check(input string what, input logic [31:0] want, input logic [31:0] got);
        total_checks++;
        if (got !== want)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, want, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // pready is sampled at the edge itself, before that edge's updates
        @(posedge clk iff pready === 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic wait_done(output logic seen);
        seen = 1'b0;
        repeat (4)
        begin
            @(negedge clk);
            if (done === 1'b1)
                seen = 1'b1;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        print_verdict();
    end

    initial
    begin
        logic [31:0] r;
        logic e, seen, to_file;
        logic [7:0] f, w, k;
        logic [10:0] ex;
        logic [23:0] dx;
        instr_s ins;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check("reset status", 8'h18, status);
        check("reset dirs", 24'hFFFFFF, {dir1, dir2, dir3});
        apb(1'b0, 8'h40, 32'h0, r, e);
        check("unmapped err", 1, e);
        check("unmapped data", 0, r);
        // every third pass uses equal operands to hit zero and carry edges
        for (int i = 0; i < 42; i++)
        begin
            r = rnd();
            ins.op = op_e'(4'(i % 7 + 1));
            ins.file_addr = (i == 0) ? 7'h7F : r[6:0];
            ins.dest_file = r[7];
            f = r[15:8];
            w = (i % 3 == 0) ? f : r[23:16];
            k = (i % 3 == 0) ? w : r[31:24];
            ins.literal = k;
            r = rnd();
            apb_wr(ADDR_FILE_PTR, 32'(ins.file_addr));
            apb_wr(ADDR_FILE_DATA, 32'(f));
            apb_wr(ADDR_WORK, 32'(w));
            apb_wr(ADDR_STATUS, 32'(r[2:0]));
            i_alu_decoder_model.issue(ins, i % 2);
            wait_done(seen);
            check("done", 1, seen);
            ex = expect_of(ins.op, f, w, k, r[2:0]);
            to_file = ins.dest_file && ins.op != OP_SUB_WORK_FROM_LITERAL
                && ins.op != OP_XOR_LITERAL_INTO_WORK;
            check("work", to_file ? w : ex[10:3], work);
            check("flags", ex[2:0], status[2:0]);
            apb(1'b0, ADDR_FILE_DATA, 32'h0, r, e);
            check("file", to_file ? ex[10:3] : f, r[7:0]);
        end
        dx = 24'hFFFFFF;
        for (int j = 0; j < 4; j++)
        begin
            r = rnd();
            apb_wr(ADDR_WORK, 32'(r[7:0]));
            ins.op = OP_LOAD_PORT_DIRECTION;
            ins.file_addr = 7'(5 + j);
            i_alu_decoder_model.issue(ins, 0);
            wait_done(seen);
            if (j < 3)
                dx[23 - 8 * j -: 8] = r[7:0];
            check("dirs", dx, {dir1, dir2, dir3});
        end
        apb_wr(ADDR_WATCHDOG, 32'h1);
        repeat (40) @(posedge clk);
        apb_wr(ADDR_WATCHDOG, 32'h0);
        apb(1'b0, ADDR_WATCHDOG, 32'h0, r, e);
        check("count moved", 1, r[15:8] !== 8'h00);
        apb_wr(ADDR_STATUS, 32'h5);
        ins.op = OP_SLEEP;
        i_alu_decoder_model.issue(ins, 0);
        wait_done(seen);
        check("sleep status", 8'h15, status);
        check("asleep", 1, stopped);
        apb(1'b0, ADDR_WATCHDOG, 32'h0, r, e);
        check("count cleared", 0, r[15:8]);
        ins.op = OP_XOR_LITERAL_INTO_WORK;
        i_alu_decoder_model.issue(ins, 0);
        wait_done(seen);
        check("dropped", 0, seen);
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(negedge clk);
        check("awake", 0, stopped);
        print_verdict();
    end
endmodule

`default_nettype wire
